// *** src/bst_map.vh ***
// bst_map.vh: instruction codes, register widths, id field layout
// assumes: included by the test port design files only
`ifndef BST_MAP_VH
`define BST_MAP_VH

`define BST_IR_W 4
`define BST_ID_W 32
`define BST_OP_EXTERNAL 4'h0
`define BST_OP_SAMPLE 4'h1
`define BST_OP_IDENT 4'h2
`define BST_OP_CLAMP 4'h3
`define BST_OP_HIGHZ 4'h4
`define BST_OP_PASS 4'hf
`define BST_IR_CAPTURE 4'h1
`define BST_ID_VER_HI 31
`define BST_ID_VER_LO 28
`define BST_ID_PART_HI 27
`define BST_ID_PART_LO 12
`define BST_ID_MAKER_HI 11
`define BST_ID_MAKER_LO 1
`define BST_ID_MARK 0
`define BST_TCK_PERIOD_NS 100
`define BST_SYS_PERIOD_NS 4

`endif

// *** src/bst_tap_fsm.v ***
// bst_tap_fsm.v: sixteen-state test access port controller
// assumes: advanced once per detected rising test clock edge
`timescale 1ns/1ps
`default_nettype none

module bst_tap_fsm (
    // clock and reset
    input wire sys_clk,
    input wire reset,
    input wire clk_en,
    // stepping
    input wire step,
    input wire mode_sel,
    input wire tap_rst,
    // state
    output reg [15:0] state_r
);

    localparam [15:0] S_RESET = 16'h0001;
    localparam [15:0] S_IDLE = 16'h0002;
    localparam [15:0] S_DSEL = 16'h0004;
    localparam [15:0] S_DCAP = 16'h0008;
    localparam [15:0] S_DSH = 16'h0010;
    localparam [15:0] S_DEX1 = 16'h0020;
    localparam [15:0] S_DPAU = 16'h0040;
    localparam [15:0] S_DEX2 = 16'h0080;
    localparam [15:0] S_DUPD = 16'h0100;
    localparam [15:0] S_ISEL = 16'h0200;
    localparam [15:0] S_ICAP = 16'h0400;
    localparam [15:0] S_ISH = 16'h0800;
    localparam [15:0] S_IEX1 = 16'h1000;
    localparam [15:0] S_IPAU = 16'h2000;
    localparam [15:0] S_IEX2 = 16'h4000;
    localparam [15:0] S_IUPD = 16'h8000;

    reg [15:0] state_nxt;

    // standard transitions on the mode select level
    always @* begin
        case (state_r)
            S_RESET: state_nxt = mode_sel ? S_RESET : S_IDLE;
            S_IDLE: state_nxt = mode_sel ? S_DSEL : S_IDLE;
            S_DSEL: state_nxt = mode_sel ? S_ISEL : S_DCAP;
            S_DCAP: state_nxt = mode_sel ? S_DEX1 : S_DSH;
            S_DSH: state_nxt = mode_sel ? S_DEX1 : S_DSH;
            S_DEX1: state_nxt = mode_sel ? S_DUPD : S_DPAU;
            S_DPAU: state_nxt = mode_sel ? S_DEX2 : S_DPAU;
            S_DEX2: state_nxt = mode_sel ? S_DUPD : S_DSH;
            S_DUPD: state_nxt = mode_sel ? S_DSEL : S_IDLE;
            S_ISEL: state_nxt = mode_sel ? S_RESET : S_ICAP;
            S_ICAP: state_nxt = mode_sel ? S_IEX1 : S_ISH;
            S_ISH: state_nxt = mode_sel ? S_IEX1 : S_ISH;
            S_IEX1: state_nxt = mode_sel ? S_IUPD : S_IPAU;
            S_IPAU: state_nxt = mode_sel ? S_IEX2 : S_IPAU;
            S_IEX2: state_nxt = mode_sel ? S_IUPD : S_ISH;
            S_IUPD: state_nxt = mode_sel ? S_DSEL : S_IDLE;
            default: state_nxt = S_RESET;
        endcase
    end

    always @(posedge sys_clk) begin
        if (reset) begin
            state_r <= S_RESET;
        end else if (clk_en) begin
            if (tap_rst) begin
                state_r <= S_RESET;
            end else if (step) begin
                state_r <= state_nxt;
            end
        end
    end

endmodule

`default_nettype wire

// *** src/bst_test_port.v ***
// bst_test_port.v: boundary-scan test access port of a dual-port memory
// assumes: test pins arrive asynchronous to sys_clk; test clock far slower
//
// Overview of operation
// - code 0000 drives boundary cells onto outputs; boundary chain is serial path.
// - code 1111 puts the single bypass bit alone in the serial path.
// - code 0010 loads the 32-bit identification value and shifts it out.
// - code 0100 floats all functional outputs; bypass bit is serial path.
// - code 0011 holds boundary cells on outputs; bypass bit is serial path.
// - code 0001 captures what the core drives to the functional pins, excluding test pins, and shifts it.
// - sample/preload shifts serial input data into the boundary cells.
// - identification bits 31:28 hold the version field.
// - identification bits 27:12 hold the part number.
// - identification bits 11:1 hold the maker code.
// - identification bit 0 is always one.
`timescale 1ns/1ps
`default_nettype none
`include "bst_map.vh"

module bst_test_port #(
    parameter BND_W = 8,
    parameter [3:0] ID_VERSION = 4'h1, // arbitrary value
    parameter [15:0] ID_PART = 16'h1234, // arbitrary value
    parameter [10:0] ID_MAKER = 11'h155  // arbitrary value
) (
    // clock and reset
    input wire sys_clk,
    input wire reset,
    input wire clk_en,
    // test pins
    input wire test_clk,
    input wire test_mode_sel,
    input wire test_rst_n,
    input wire test_din,
    output reg test_dout_r,
    output reg test_dout_oe_r,
    // functional pins seen by the boundary chain
    input wire [BND_W-1:0] core_out,
    input wire [BND_W-1:0] pin_in,
    output reg [BND_W-1:0] pin_out_r,
    output reg pin_oe_r,
    output reg [BND_W-1:0] core_in_r
);

    // ==========================================
    // pin synchronisers
    reg [3:0] sync1_r;
    reg [3:0] sync2_r;
    reg tck_d_r;
    wire tck_s = sync2_r[0];
    wire tms_s = sync2_r[1];
    // test reset arrives active low and is inverted after the second flop
    wire trst_s = ~sync2_r[2];
    wire tdi_s = sync2_r[3];
    wire rise = tck_s & ~tck_d_r;
    wire fall = ~tck_s & tck_d_r;

    // reset values mirror idle pins, so no false edge or test reset follows reset
    always @(posedge sys_clk) begin
        if (reset) begin
            sync1_r <= 4'h4;
            sync2_r <= 4'h4;
            tck_d_r <= 1'b0;
        end else if (clk_en) begin
            sync1_r <= {test_din, test_rst_n, test_mode_sel, test_clk};
            sync2_r <= sync1_r;
            tck_d_r <= sync2_r[0];
        end
    end

    // ==========================================
    // controller
    wire [15:0] st;

    // the controller steps only on detected rises; test reset overrides stepping
    bst_tap_fsm i_bst_tap_fsm (
        .sys_clk(sys_clk),
        .reset(reset),
        .clk_en(clk_en),
        .step(rise),
        .mode_sel(tms_s),
        .tap_rst(trst_s),
        .state_r(st)
    );

    wire s_reset = st[0];
    wire s_dcap = st[3];
    wire s_dsh = st[4];
    wire s_dupd = st[8];
    wire s_icap = st[10];
    wire s_ish = st[11];
    wire s_iupd = st[15];

    // ==========================================
    // registers
    reg [`BST_IR_W-1:0] test_instruction_r;
    reg [`BST_IR_W-1:0] ir_shift_r;
    reg single_bit_passthrough_r;
    reg [`BST_ID_W-1:0] id_shift_r;
    // boundary shift stage is kept apart from the held value driven to the pins
    reg [BND_W-1:0] bnd_shift_r;
    reg [BND_W-1:0] bnd_hold_r;
    wire [`BST_ID_W-1:0] device_identification;

    // fixed identification word; bit 0 marks that the register exists
    assign device_identification[`BST_ID_VER_HI:`BST_ID_VER_LO] = ID_VERSION;
    assign device_identification[`BST_ID_PART_HI:`BST_ID_PART_LO] = ID_PART;
    assign device_identification[`BST_ID_MAKER_HI:`BST_ID_MAKER_LO] = ID_MAKER;
    assign device_identification[`BST_ID_MARK] = 1'b1;

    // ==========================================
    // instruction decode
    wire op_ext = (test_instruction_r == `BST_OP_EXTERNAL);
    wire op_smp = (test_instruction_r == `BST_OP_SAMPLE);
    wire op_id = (test_instruction_r == `BST_OP_IDENT);
    wire op_clamp = (test_instruction_r == `BST_OP_CLAMP);
    wire op_hz = (test_instruction_r == `BST_OP_HIGHZ);
    // reserved codes fall back to the bypass path and leave the pins alone,
    // so a stray code cannot float or clamp the memory outputs
    wire use_bnd = op_ext | op_smp;
    wire use_id = op_id;
    // external test captures the pins, sample captures what the core drives out
    wire [BND_W-1:0] bnd_capture = op_ext ? pin_in : core_out;

    // ==========================================
    // instruction path
    // a new code takes effect on the fall, while the controller is not sampling
    always @(posedge sys_clk) begin
        if (reset) begin
            ir_shift_r <= `BST_IR_CAPTURE;
            test_instruction_r <= `BST_OP_IDENT;
        end else if (clk_en) begin
            if (s_reset) begin
                test_instruction_r <= `BST_OP_IDENT;
            end else if (rise & s_icap) begin
                ir_shift_r <= `BST_IR_CAPTURE;
            end else if (rise & s_ish) begin
                ir_shift_r <= {tdi_s, ir_shift_r[`BST_IR_W-1:1]};
            end else if (fall & s_iupd) begin
                test_instruction_r <= ir_shift_r;
            end
        end
    end

    // ==========================================
    // data paths
    // bypass and id registers always capture and shift, boundary only under codes 0000 and 0001; the decode picks the one seen
    always @(posedge sys_clk) begin
        if (reset) begin
            single_bit_passthrough_r <= 1'b0;
            id_shift_r <= {`BST_ID_W{1'b0}};
            bnd_shift_r <= {BND_W{1'b0}};
            bnd_hold_r <= {BND_W{1'b0}};
        end else if (clk_en & rise) begin
            if (s_dcap) begin
                single_bit_passthrough_r <= 1'b0;
                id_shift_r <= device_identification;
                if (use_bnd) begin
                    bnd_shift_r <= bnd_capture;
                end
            end else if (s_dsh) begin
                single_bit_passthrough_r <= tdi_s;
                id_shift_r <= {tdi_s, id_shift_r[`BST_ID_W-1:1]};
                if (use_bnd) begin
                    bnd_shift_r <= {tdi_s, bnd_shift_r[BND_W-1:1]};
                end
            end
        end else if (clk_en & fall & s_dupd & use_bnd) begin
            bnd_hold_r <= bnd_shift_r;
        end
    end

    // ==========================================
    // serial output on falling edge
    reg tdo_nxt;
    // output enable follows the shift states so the line floats between scans
    wire shifting = s_ish | s_dsh;

    // instruction shifting wins; otherwise the decoded data register drives out
    always @* begin
        if (s_ish) begin
            tdo_nxt = ir_shift_r[0];
        end else if (use_bnd) begin
            tdo_nxt = bnd_shift_r[0];
        end else if (use_id) begin
            tdo_nxt = id_shift_r[0];
        end else begin
            tdo_nxt = single_bit_passthrough_r;
        end
    end

    always @(posedge sys_clk) begin
        if (reset) begin
            test_dout_r <= 1'b0;
            test_dout_oe_r <= 1'b0;
        end else if (clk_en & fall) begin
            test_dout_r <= tdo_nxt;
            test_dout_oe_r <= shifting;
        end
    end

    // ==========================================
    // functional pin muxing
    // the core path runs under every code; only the pin side is switched
    wire drive_cells = op_ext | op_clamp;

    always @(posedge sys_clk) begin
        if (reset) begin
            pin_out_r <= {BND_W{1'b0}};
            pin_oe_r <= 1'b1;
            core_in_r <= {BND_W{1'b0}};
        end else if (clk_en) begin
            pin_out_r <= drive_cells ? bnd_hold_r : core_out;
            pin_oe_r <= ~op_hz;
            core_in_r <= pin_in;
        end
    end

endmodule

`default_nettype wire

// *** testbench/bst_checker.sv ***
// bst_checker.sv: timing relations at the test port pins
// assumes: bound to bst_test_port, one sys_clk domain
`timescale 1ns/1ps
`default_nettype none
module bst_checker #(parameter int BND_W = 8) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    input wire logic clk_en,
    // test pins
    input wire logic test_clk,
    input wire logic test_dout_r,
    input wire logic test_dout_oe_r,
    // functional pins
    input wire logic [BND_W-1:0] core_out,
    input wire logic [BND_W-1:0] pin_in,
    input wire logic [BND_W-1:0] pin_out_r,
    input wire logic pin_oe_r,
    input wire logic [BND_W-1:0] core_in_r
);
    // ==========
    // properties
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    a_reset_state: assert property (disable iff (1'b0) reset |=>
        !test_dout_r && !test_dout_oe_r && pin_oe_r) else $error("bad state after reset");
    a_core_in_pass: assert property (clk_en |=> core_in_r == $past(pin_in))
        else $error("core input not passed through");
    a_dout_on_fall: assert property ($changed(test_dout_r) |-> !test_clk)
        else $error("serial out moved with test clock high");
    a_dout_stands: assert property ($changed(test_dout_r) |=> $stable(test_dout_r) [*8])
        else $error("serial out did not stand");
    a_dout_oe_fall: assert property ($changed(test_dout_oe_r) |-> !test_clk)
        else $error("serial enable moved with test clock high");
    a_highz_holds: assert property ($fell(pin_oe_r) |=> !pin_oe_r [*8])
        else $error("high impedance not held");
    a_oe_on_fall: assert property ($changed(pin_oe_r) |-> !test_clk)
        else $error("output enable moved with test clock high");
    a_hold_on_fall: assert property (!$past(reset) && $changed(pin_out_r) &&
        $past(core_out) == $past(core_out, 2) |-> !test_clk) else $error("pin hold moved");
    c_highz: cover property ($fell(pin_oe_r));
    c_shift: cover property ($rose(test_dout_oe_r));
    c_hold: cover property (pin_out_r != core_out);
endmodule
`default_nettype wire

// *** testbench/bst_ctrl_model.sv ***
// bst_ctrl_model.sv: test controller driving the scan pins
// assumes: tasks entered at a sys_clk falling edge, test_clk low
`timescale 1ns/1ps
`default_nettype none
module bst_ctrl_model (
    // test pins
    output logic test_clk,
    output logic test_mode_sel,
    output logic test_rst_n,
    output logic test_din,
    input wire logic test_dout_r
);
    // ==========
    // stepping
    initial begin
        test_clk = 1'b0;
        test_mode_sel = 1'b1;
        test_rst_n = 1'b1;
        test_din = 1'b0;
    end
    // one test clock; returns serial out seen just before the rise
    task automatic step(input logic ms, input logic di, output logic q);
        test_mode_sel = ms;
        test_din = di;
        #80 q = test_dout_r;
        test_clk = 1'b1;
        #80 test_clk = 1'b0;
    endtask
    // idle to idle through a shift of len bits, lsb first
    task automatic scan(input logic ir, input int len, input logic [31:0] d,
        output logic [31:0] q);
        logic x;
        q = '0;
        step(1'b1, 1'b0, x);
        if (ir) step(1'b1, 1'b0, x);
        step(1'b0, 1'b0, x);
        step(1'b0, 1'b0, x);
        for (int i = 0; i < len; i++) begin
            step(i == len - 1, d[i], x);
            q[i] = x;
        end
        step(1'b1, 1'b0, x);
        step(1'b0, 1'b0, x);
    endtask
    task automatic trst();
        logic x;
        test_rst_n = 1'b0;
        #80 test_rst_n = 1'b1;
        #80 step(1'b0, 1'b0, x);
    endtask
endmodule
`default_nettype wire

// *** testbench/test_bst_test_port.sv ***
// test_bst_test_port.sv: self-checking bench for the test port
// assumes: bst_ctrl_model drives the scan pins
`timescale 1ns/1ps
`default_nettype none
module test_bst_test_port;
    // ==========
    // signals
    localparam logic [31:0] ID = {4'h3, 16'h2468, 11'h0a5, 1'b1}; // arbitrary fields
    localparam logic [31:0] D = 32'h9e37_4c21;
    logic sys_clk = 1'b0, reset = 1'b1, clk_en = 1'b1;
    logic [7:0] core_out = 8'h5a, pin_in = 8'hc3;
    wire test_clk, test_mode_sel, test_rst_n, test_din, test_dout_r, test_dout_oe_r, pin_oe_r;
    wire [7:0] pin_out_r, core_in_r;
    int errors = 0, samples_checked = 0;
    logic [31:0] got;
    logic [3:0] row_code [6] = '{4'h1, 4'h0, 4'h3, 4'h4, 4'hf, 4'h2};
    logic row_oe [6] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
    logic [7:0] row_pin [6] = '{8'h5a, 8'h9e, 8'h9e, 8'h5a, 8'h5a, 8'h5a};
    logic [31:0] row_dr [6] = '{{D[23:0], 8'h5a}, {D[23:0], 8'hc3}, {D[30:0], 1'b0},
        {D[30:0], 1'b0}, {D[30:0], 1'b0}, ID};
    bst_test_port #(.BND_W(8), .ID_VERSION(4'h3), .ID_PART(16'h2468), .ID_MAKER(11'h0a5))
        i_bst_test_port (.sys_clk, .reset, .clk_en, .test_clk, .test_mode_sel, .test_rst_n,
        .test_din, .test_dout_r, .test_dout_oe_r, .core_out, .pin_in, .pin_out_r, .pin_oe_r,
        .core_in_r);
    bst_ctrl_model i_bst_ctrl_model (.test_clk, .test_mode_sel, .test_rst_n, .test_din,
        .test_dout_r);
    always #2 sys_clk = ~sys_clk;
    // ==========
    // checking
    task automatic check(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #200000;
        errors++;
        test_done();
    end
    // ==========
    // sequence
    initial begin
        repeat (10) @(negedge sys_clk);
        check(pin_oe_r, 1'b1);
        check(test_dout_oe_r, 1'b0);
        reset = 1'b0;
        repeat (4) @(negedge sys_clk);
        i_bst_ctrl_model.trst();
        for (int r = 0; r < 6; r++) begin
            i_bst_ctrl_model.scan(1'b1, 4, {28'h0, row_code[r]}, got);
            check(got, 32'h1);
            check(pin_oe_r, row_oe[r]);
            check(pin_out_r, row_pin[r]);
            i_bst_ctrl_model.scan(1'b0, 32, D, got);
            check(got, row_dr[r]);
            $display("row %0d code %h done", r, row_code[r]);
        end
        i_bst_ctrl_model.scan(1'b1, 4, 32'hf, got);
        i_bst_ctrl_model.trst();
        i_bst_ctrl_model.scan(1'b0, 32, D, got);
        check(got, ID);
        $display("test reset case done");
        // system reset in mid-run, taken while high impedance is selected
        i_bst_ctrl_model.scan(1'b1, 4, 32'h4, got);
        check(got, 32'h1);
        check(pin_oe_r, 1'b0);
        reset = 1'b1;
        repeat (10) @(negedge sys_clk);
        check(pin_out_r, 8'h00);
        check(test_dout_r, 1'b0);
        reset = 1'b0;
        repeat (4) @(negedge sys_clk);
        check(pin_oe_r, 1'b1);
        i_bst_ctrl_model.step(1'b0, 1'b0, got[0]);
        i_bst_ctrl_model.scan(1'b0, 32, D, got);
        check(got, ID);
        $display("mid-run reset case done");
        // clock enable low freezes the memory path, which then resumes
        clk_en = 1'b0;
        pin_in = 8'h3c;
        core_out = 8'ha5;
        repeat (4) @(negedge sys_clk);
        check(core_in_r, 8'hc3);
        check(pin_out_r, 8'h5a);
        clk_en = 1'b1;
        repeat (3) @(negedge sys_clk);
        check(core_in_r, 8'h3c);
        check(pin_out_r, 8'ha5);
        $display("clock enable case done");
        test_done();
    end
endmodule
bind bst_test_port bst_checker #(.BND_W(BND_W)) i_bst_checker (.sys_clk, .reset, .clk_en,
    .test_clk, .test_dout_r, .test_dout_oe_r, .core_out, .pin_in, .pin_out_r, .pin_oe_r,
    .core_in_r);
`default_nettype wire
